/* bench/pin_source.sv */
`timescale 1ns/1ps
module pin_source (
	input  wire logic clock,
	output logic      count_level,
	output logic      trigger_level
);
	initial begin
		count_level = 1'b1;
		trigger_level = 1'b1;
	end
	// Each level held hold clocks, never shorter than the sample spacing
	task automatic count_pulses(input int n, input int hold);
		repeat (n) begin
			repeat (hold) @(posedge clock);
			count_level <= 1'b0;
			repeat (hold) @(posedge clock);
			count_level <= 1'b1;
		end
	endtask : count_pulses
	task automatic trigger_fall();
		@(posedge clock);
		trigger_level <= 1'b0;
		repeat (4) @(posedge clock);
		trigger_level <= 1'b1;
	endtask : trigger_fall
endmodule : pin_source

/* bench/timer2_monitor.sv */
`timescale 1ns/1ps
`include "timer2_defs.svh"
module timer2_monitor (
	input wire logic        clock,
	input wire logic        resetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic        hresp,
	input wire logic        count_pin_oe,
	input wire logic        other_timer_overflow,
	input wire logic        receive_clock_pulse,
	input wire logic        transmit_clock_pulse,
	input wire logic        timer_irq
);
	logic [7:0] idx;
	logic [7:0] sh_ctl;
	logic [7:0] sh_mod;
	logic [7:0] sh_clk;
	logic       wr;
	logic       rd;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wr <= 1'b0;
			rd <= 1'b0;
			idx <= 8'h00;
		end else if (hready) begin
			wr <= hsel & htrans[1] & hwrite;
			rd <= hsel & htrans[1] & !hwrite;
			idx <= haddr[9:2];
		end
	end
	// Written values; mode and clock masked, control flags stored but left unchecked
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sh_ctl <= `RST_TIMER_CONTROL;
			sh_mod <= `RST_TIMER_MODE_CONTROL;
			sh_clk <= `RST_CLOCK_CONTROL;
		end else if (wr) begin
			if (idx == `IDX_TIMER_CONTROL)
				sh_ctl <= hwdata[7:0];
			if (idx == `IDX_TIMER_MODE_CONTROL)
				sh_mod <= hwdata[7:0] & `MOD_WRITE_MASK;
			if (idx == `IDX_CLOCK_CONTROL)
				sh_clk <= hwdata[7:0] & `CLK_WRITE_MASK;
		end
	end
	ready_okay_a: assert property (hreadyout && hresp == `HRESP_OKAY)
		else $error("bus answer not ready and okay");
	upper_zero_a: assert property (rd |-> hrdata[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	unmapped_zero_a: assert property (rd && (idx < 8'hC8 || idx > 8'hCE)
		|-> hrdata == 32'h00000000) else $error("unmapped read not zero");
	ctl_read_a: assert property (rd && idx == `IDX_TIMER_CONTROL
		|-> hrdata[5:0] == $past(sh_ctl[5:0])) else $error("control readback");
	mod_read_a: assert property (rd && idx == `IDX_TIMER_MODE_CONTROL
		|-> hrdata[7:0] == $past(sh_mod)) else $error("mode readback");
	clk_read_a: assert property (rd && idx == `IDX_CLOCK_CONTROL
		|-> hrdata[7:0] == $past(sh_clk)) else $error("clock readback");
	rx_route_a: assert property (!sh_ctl[5] && !$past(sh_ctl[5])
		|-> receive_clock_pulse == $past(other_timer_overflow))
		else $error("receive clock not from other timer");
	tx_route_a: assert property (!sh_ctl[4] && !$past(sh_ctl[4])
		|-> transmit_clock_pulse == $past(other_timer_overflow))
		else $error("transmit clock not from other timer");
	irq_masked_a: assert property (!sh_clk[6] && !$past(sh_clk[6])
		|-> !timer_irq) else $error("interrupt while disabled");
	pin_drive_a: assert property ($stable(sh_mod) && $stable(sh_ctl[1])
		|-> count_pin_oe == (sh_mod[1] && !sh_ctl[1]))
		else $error("count pin drive enable wrong");
endmodule : timer2_monitor
bind timer2_reload_capture_counter timer2_monitor timer2_monitor_i (.*);

/* bench/timer2_reload_capture_counter_tb_top.sv */
`timescale 1ns/1ps
module timer2_reload_capture_counter_tb_top;
	logic        clock, resetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize = 3'h2;
	logic        count_pin_in, count_pin_out, count_pin_oe, trigger_pin_in;
	logic        other_timer_overflow, receive_clock_pulse;
	logic        transmit_clock_pulse, timer_irq, count_level, p;
	logic [7:0]  rv, a, d;
	int          failures = 0, tests_run = 0, cyc = 0, stamp, n;
	assign hready = hreadyout;
	assign count_pin_in = count_pin_oe ? count_pin_out : count_level;
	timer2_reload_capture_counter timer2_reload_capture_counter_i (.*);
	pin_source pin_source_i (.clock(clock), .count_level(count_level),
		.trigger_level(trigger_pin_in));
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	always @(posedge clock) cyc <= cyc + 1;
	task automatic stop_test();
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test
	task automatic check(input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("FAIL %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic rdy();
		int k;
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (hready !== 1'b1 && k < 99);
		if (k >= 99) begin
			failures++;
			stop_test();
		end
	endtask : rdy
	task automatic xfer(input logic w, input logic [7:0] i, dat);
		hsel <= 1'b1;
		haddr <= {22'h000000, i, 2'h0};
		htrans <= 2'h2;
		hwrite <= w;
		rdy();
		stamp = cyc;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h000000, dat};
		rdy();
		rv = hrdata[7:0];
	endtask : xfer
	task automatic reset_values();
		logic [7:0] ix[8] = '{8'hC8, 8'hC9, 8'hCA, 8'hCB, 8'hCC, 8'hCD,
			8'hCE, 8'hC0};
		xfer(1'b1, 8'hC0, 8'hFF);
		foreach (ix[j]) begin
			xfer(1'b0, ix[j], 8'h00);
			check(rv, ix[j] == 8'hCE ? 8'h25 : 8'h00);
		end
	endtask : reset_values
	// Count delta over a span that is a whole number of ticks
	task automatic tick_rates();
		logic [7:0] ck[6] = '{8'h00, 8'h13, 8'h25, 8'h35, 8'h35, 8'h00};
		logic [7:0] ct[6] = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h14, 8'h00};
		int dv[6] = '{1, 4, 6, 12, 1, 1};
		int c1;
		foreach (dv[j]) begin
			xfer(1'b1, 8'hCE, ck[j]);
			xfer(1'b1, 8'hCD, 8'h00);
			xfer(1'b1, 8'hC8, ct[j]);
			xfer(1'b0, 8'hCC, 8'h00);
			a = rv;
			c1 = stamp;
			repeat (24 * dv[j] - 2) @(posedge clock);
			xfer(1'b0, 8'hCC, 8'h00);
			d = rv - a;
			check(d, ct[j][2] ? (stamp - c1) / dv[j] : 0);
		end
	endtask : tick_rates
	task automatic events();
		xfer(1'b1, 8'hCE, 8'h00);
		xfer(1'b1, 8'hC8, 8'h06);
		xfer(1'b0, 8'hCC, 8'h00);
		a = rv;
		pin_source_i.count_pulses(5, 1);
		repeat (6) @(posedge clock);
		xfer(1'b0, 8'hCC, 8'h00);
		d = rv - a;
		check(d, 5);
		xfer(1'b1, 8'hCE, 8'h25);
		xfer(1'b0, 8'hCC, 8'h00);
		a = rv;
		pin_source_i.count_pulses(3, 6);
		repeat (12) @(posedge clock);
		xfer(1'b0, 8'hCC, 8'h00);
		d = rv - a;
		check(d, 3);
	endtask : events
	task automatic overflow();
		xfer(1'b1, 8'hC8, 8'h00);
		xfer(1'b1, 8'hCE, 8'h40);
		xfer(1'b1, 8'hCA, 8'h34);
		xfer(1'b1, 8'hCB, 8'h12);
		xfer(1'b1, 8'hCD, 8'hFF);
		xfer(1'b1, 8'hCC, 8'hF0);
		xfer(1'b1, 8'hC8, 8'h04);
		repeat (40) @(posedge clock);
		xfer(1'b0, 8'hC8, 8'h00);
		check(rv, 8'h84);
		check(timer_irq, 1'b1);
		xfer(1'b0, 8'hCD, 8'h00);
		check(rv, 8'h12);
		xfer(1'b1, 8'hC8, 8'h00);
		xfer(1'b0, 8'hC8, 8'h00);
		check(rv, 8'h00);
		repeat (2) @(posedge clock);
		check(timer_irq, 1'b0);
		other_timer_overflow <= 1'b1;
		@(posedge clock);
		other_timer_overflow <= 1'b0;
		xfer(1'b1, 8'hCD, 8'hFF);
		xfer(1'b1, 8'hC8, 8'h24);
		n = 0;
		repeat (300) begin
			@(posedge clock);
			n += receive_clock_pulse;
		end
		check(n != 0, 1'b1);
		xfer(1'b0, 8'hC8, 8'h00);
		check(rv, 8'h24);
	endtask : overflow
	task automatic capture();
		xfer(1'b1, 8'hC8, 8'h05);
		pin_source_i.trigger_fall();
		repeat (6) @(posedge clock);
		xfer(1'b0, 8'hC8, 8'h00);
		check(rv, 8'h05);
		xfer(1'b1, 8'hC8, 8'h0D);
		pin_source_i.trigger_fall();
		repeat (6) @(posedge clock);
		xfer(1'b0, 8'hC8, 8'h00);
		check(rv, 8'h4D);
		check(timer_irq, 1'b1);
		xfer(1'b1, 8'hC9, 8'h01);
		repeat (2) @(posedge clock);
		check(timer_irq, 1'b0);
	endtask : capture
	task automatic toggle_out();
		xfer(1'b1, 8'hC8, 8'h00);
		xfer(1'b1, 8'hCA, 8'h34);
		xfer(1'b1, 8'hCB, 8'h12);
		xfer(1'b1, 8'hCD, 8'hFF);
		xfer(1'b1, 8'hCC, 8'hF0);
		xfer(1'b1, 8'hC9, 8'h02);
		xfer(1'b1, 8'hC8, 8'h04);
		p = count_pin_out;
		repeat (40) @(posedge clock);
		check(count_pin_out, !p);
	endtask : toggle_out
	initial begin
		resetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h00000000;
		other_timer_overflow = 1'b0;
		repeat (4) @(posedge clock);
		resetn <= 1'b1;
		reset_values();
		tick_rates();
		events();
		overflow();
		capture();
		toggle_out();
		stop_test();
	end
endmodule : timer2_reload_capture_counter_tb_top

/* src/tick_gen.sv */
`timescale 1ns/1ps
`include "timer2_defs.svh"
module tick_gen (
	input  wire logic clock,
	input  wire logic resetn,
	tick_if.source    tk
);
	import timer2_pkg::*;

	prescale_t pcount;
	logic      half;
	logic      pre_tick;

	assign pre_tick = (pcount == tk.prescale_setting);

	// Divide by setting plus one
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			pcount <= 4'h0;
		else if (pre_tick)
			pcount <= 4'h0;
		else
			pcount <= pcount + 4'h1;
	end

	// Extra halving for double speed in compatibility operation
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			half <= 1'b0;
		else if (pre_tick)
			half <= ~half;
	end

	always_comb begin
		if (tk.bypass)
			tk.tick = 1'b1; // R7
		else if (tk.compat_mode)
			tk.tick = tk.double_speed_select ? (pre_tick & half) // R5
				: pre_tick; // R4 R3
		else
			tk.tick = tk.double_speed_select ? pre_tick : 1'b1; // R6
	end

	// Pin sampling is paced in compatibility operation only
	assign tk.sample = tk.compat_mode ? pre_tick : 1'b1; // R10 R8

endmodule : tick_gen

/* src/tick_if.sv */
`timescale 1ns/1ps
interface tick_if;
	import timer2_pkg::*;

	prescale_t prescale_setting;
	logic      double_speed_select;
	logic      compat_mode;
	logic      bypass;
	logic      tick;
	logic      sample;

	modport source (
		input  prescale_setting,
		input  double_speed_select,
		input  compat_mode,
		input  bypass,
		output tick,
		output sample
	);

	modport sink (
		output prescale_setting,
		output double_speed_select,
		output compat_mode,
		output bypass,
		input  tick,
		input  sample
	);

endinterface : tick_if

/* src/timer2_defs.svh */
`ifndef TIMER2_DEFS_SVH
`define TIMER2_DEFS_SVH

// Register indices; byte address is four times the index
`define IDX_TIMER_CONTROL      8'hC8
`define IDX_TIMER_MODE_CONTROL 8'hC9
`define IDX_RELOAD_LOW         8'hCA
`define IDX_RELOAD_HIGH        8'hCB
`define IDX_COUNT_LOW          8'hCC
`define IDX_COUNT_HIGH         8'hCD
`define IDX_CLOCK_CONTROL      8'hCE
`define IDX_LSB                2
`define IDX_MSB                9

// Timer control bits
`define CTL_OVERFLOW_FLAG      7
`define CTL_EXTERNAL_FLAG      6
`define CTL_RECEIVE_CLOCK      5
`define CTL_TRANSMIT_CLOCK     4
`define CTL_EXTERNAL_ENABLE    3
`define CTL_RUN_CONTROL        2
`define CTL_COUNTER_SELECT     1
`define CTL_CAPTURE_SELECT     0

// Mode control bits
`define MOD_OUTPUT_TOGGLE      1
`define MOD_DOWN_COUNT         0
`define MOD_WRITE_MASK         8'h03

// Clock control bits
`define CLK_PRESCALE_LSB       0
`define CLK_PRESCALE_MSB       3
`define CLK_DOUBLE_SPEED       4
`define CLK_COMPAT_MODE        5
`define CLK_INT_ENABLE         6
`define CLK_WRITE_MASK         8'h7F

// Reset values
`define RST_TIMER_CONTROL      8'h00
`define RST_TIMER_MODE_CONTROL 8'h00
`define RST_CLOCK_CONTROL      8'h25
`define RST_COUNT              16'h0000
`define RST_RELOAD             16'h0000
`define RST_PRESCALE           4'h5

// Count limits
`define COUNT_MIN              16'h0000
`define COUNT_MAX              16'hFFFF

// AHB fields
`define HTRANS_ACTIVE_BIT      1
`define HRESP_OKAY             1'b0

`endif

/* src/timer2_pkg.sv */
package timer2_pkg;

	typedef enum logic [2:0] {
		MODE_OFF         = 3'b000,
		MODE_AUTO_RELOAD = 3'b001,
		MODE_AUTO_UPDOWN = 3'b010,
		MODE_CAPTURE     = 3'b011,
		MODE_BAUD        = 3'b100,
		MODE_FREQ        = 3'b101
	} mode_t;

	typedef logic [3:0] prescale_t;

endpackage : timer2_pkg

/* src/timer2_reload_capture_counter.sv */
// Notes on behaviour
// R1 - Sixteen-bit count of two bytes, incremented, or decremented when counting down, on each enabled tick.
// R2 - Counter select picks clock ticks or count pin edges.
// R3 - Prescaled tick rate is system clock over prescale setting plus one.
// R4 - Compatibility operation prescales except as baud or frequency generator; setting resets to five.
// R5 - Double speed in compatibility operation halves the tick rate again.
// R6 - Fast operation bypasses prescaler unless double speed is set.
// R7 - Baud and frequency generator ignore prescaler and double speed.
// R8 - Fast event counting samples every clock; high then low counts.
// R9 - Count shows the cycle after edge detection; half clock maximum.
// R10 - Compatibility operation samples the count pin at prescaler pace.
// R11 - Source holds each count pin level one, or six, clocks.
// R12 - Run set: serial clock, toggle, capture, else reload or up/down.
// R13 - Minimum zero, maximum all ones; reload value from reload bytes.
// R14 - Count and reload bytes at their fixed register indices.
// R15 - Hardware sets overflow flag on overflow; software writes set or clear it.
// R16 - Hardware never sets overflow flag while either serial clock select is set.
// R17 - Overflow flag requests interrupt when timer interrupt enabled.
// R18 - Trigger falling edge capture or reload sets external flag.
// R19 - External flag requests no interrupt in up/down operation.
// R20 - External enable clear ignores trigger falling edges.
// R21 - Run control starts counting; clear stops and holds the count.
// R22 - Receive clock select routes overflows to reception, else other.
// R23 - Toggle enable with timer operation toggles count pin on overflow.
// R24 - Count and trigger pins pass two synchroniser stages.
// R25 - Hardware flag set wins over a same cycle software write.
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
`include "timer2_defs.svh"
module timer2_reload_capture_counter (
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	input  wire logic        count_pin_in,
	output logic             count_pin_out,
	output logic             count_pin_oe,
	input  wire logic        trigger_pin_in,
	input  wire logic        other_timer_overflow,
	output logic             receive_clock_pulse,
	output logic             transmit_clock_pulse,
	output logic             timer_irq
);
	import timer2_pkg::*;

	logic [7:0]  timer_control;
	logic [7:0]  timer_mode_control;
	logic [7:0]  clock_control;
	logic [15:0] count;
	logic [15:0] reload_value;

	mode_t       mode;
	logic        wr_pending;
	logic [7:0]  wr_index;
	logic        wr_en;
	logic [7:0]  wr_byte;
	logic        rd_take;
	logic [7:0]  rd_index;
	logic        wr_control;
	logic        wr_mode;
	logic        wr_clock;
	logic        wr_count_low;
	logic        wr_count_high;
	logic        wr_reload_low;
	logic        wr_reload_high;

	logic [1:0]  sync_a;
	logic [1:0]  sync_b;
	logic [1:0]  pins_raw;
	logic        count_level;
	logic        trigger_level;
	logic        count_sample;
	logic        pin_fall;
	logic        trigger_prev;
	logic        trigger_fall;

	logic        step;
	logic        count_down;
	logic        top_hit;
	logic        reload_value_hit;
	logic        overflow;
	logic        ext_event;
	logic        serial_clock;
	logic [15:0] next_count;
	logic [15:0] next_reload;
	logic [7:0]  next_control;

	tick_if tk ();

	function automatic mode_t decode_mode(input logic [7:0] ctl,
		input logic [7:0] mdc);
		if (!ctl[`CTL_RUN_CONTROL])
			return MODE_OFF;
		if (ctl[`CTL_RECEIVE_CLOCK] || ctl[`CTL_TRANSMIT_CLOCK])
			return MODE_BAUD;
		if (mdc[`MOD_OUTPUT_TOGGLE])
			return MODE_FREQ;
		if (ctl[`CTL_CAPTURE_SELECT])
			return MODE_CAPTURE;
		if (mdc[`MOD_DOWN_COUNT])
			return MODE_AUTO_UPDOWN;
		return MODE_AUTO_RELOAD;
	endfunction : decode_mode

	function automatic logic [7:0] word_index(input logic [31:0] addr);
		return addr[`IDX_MSB:`IDX_LSB];
	endfunction : word_index

	// Register write strobe for one index
	function automatic logic write_hit(input logic en,
		input logic [7:0] at, input logic [7:0] want);
		return en && (at == want);
	endfunction : write_hit

	assign mode = decode_mode(timer_control, timer_mode_control); // R12

	assign tk.prescale_setting =
		clock_control[`CLK_PRESCALE_MSB:`CLK_PRESCALE_LSB];
	assign tk.double_speed_select = clock_control[`CLK_DOUBLE_SPEED];
	assign tk.compat_mode = clock_control[`CLK_COMPAT_MODE];
	assign tk.bypass = (mode == MODE_BAUD) || (mode == MODE_FREQ); // R7

	tick_gen u_tick_gen (
		.clock  (clock),
		.resetn (resetn),
		.tk     (tk.source)
	);

	// Bus slave: zero wait states, read data registered at address phase
	assign hreadyout = 1'b1;
	assign hresp = `HRESP_OKAY;
	assign rd_take = hsel && hready && htrans[`HTRANS_ACTIVE_BIT] && !hwrite;
	assign rd_index = word_index(haddr);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wr_pending <= 1'b0;
			wr_index <= 8'h00;
		end else if (hready) begin
			wr_pending <= hsel && htrans[`HTRANS_ACTIVE_BIT] && hwrite;
			wr_index <= word_index(haddr);
		end
	end

	assign wr_en = wr_pending;
	assign wr_byte = hwdata[7:0];

	// One strobe per register, decoded once
	assign wr_control = write_hit(wr_en, wr_index, `IDX_TIMER_CONTROL);
	assign wr_mode = write_hit(wr_en, wr_index, `IDX_TIMER_MODE_CONTROL);
	assign wr_clock = write_hit(wr_en, wr_index, `IDX_CLOCK_CONTROL);
	assign wr_count_low = write_hit(wr_en, wr_index, `IDX_COUNT_LOW);
	assign wr_count_high = write_hit(wr_en, wr_index, `IDX_COUNT_HIGH);
	assign wr_reload_low = write_hit(wr_en, wr_index, `IDX_RELOAD_LOW);
	assign wr_reload_high = write_hit(wr_en, wr_index, `IDX_RELOAD_HIGH);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			hrdata <= 32'h0000_0000;
		else if (rd_take) begin
			case (rd_index)
			`IDX_TIMER_CONTROL: hrdata <= {24'h0, timer_control};
			`IDX_TIMER_MODE_CONTROL: hrdata <= {24'h0, timer_mode_control};
			`IDX_RELOAD_LOW: hrdata <= {24'h0, reload_value[7:0]}; // R14
			`IDX_RELOAD_HIGH: hrdata <= {24'h0, reload_value[15:8]};
			`IDX_COUNT_LOW: hrdata <= {24'h0, count[7:0]};
			`IDX_COUNT_HIGH: hrdata <= {24'h0, count[15:8]};
			`IDX_CLOCK_CONTROL: hrdata <= {24'h0, clock_control};
			default: hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// Pin synchronisers
	assign pins_raw = {trigger_pin_in, count_pin_in};

	generate
		for (genvar i = 0; i < 2; i++) begin : g_sync
			always_ff @(posedge clock or negedge resetn) begin
				if (!resetn) begin
					sync_a[i] <= 1'b1;
					sync_b[i] <= 1'b1;
				end else begin
					sync_a[i] <= pins_raw[i]; // R24
					sync_b[i] <= sync_a[i];
				end
			end
		end
	endgenerate

	assign count_level = sync_b[0];
	assign trigger_level = sync_b[1];

	// Count pin edge: one pulse, so count moves the cycle after
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			count_sample <= 1'b1;
			pin_fall <= 1'b0;
		end else begin
			pin_fall <= tk.sample && count_sample && !count_level; // R8
			if (tk.sample)
				count_sample <= count_level; // R10
		end
	end

	// Trigger edge watched every clock
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			trigger_prev <= 1'b1;
		else
			trigger_prev <= trigger_level;
	end

	assign trigger_fall = trigger_prev && !trigger_level;

	// Counting
	assign serial_clock = timer_control[`CTL_RECEIVE_CLOCK] ||
		timer_control[`CTL_TRANSMIT_CLOCK];
	assign step = (mode != MODE_OFF) && // R21
		(timer_control[`CTL_COUNTER_SELECT] ? pin_fall : tk.tick); // R2 R9
	// Trigger low selects downward counting in up/down operation
	assign count_down = (mode == MODE_AUTO_UPDOWN) && !trigger_level;
	assign top_hit = (count == `COUNT_MAX); // R13
	assign reload_value_hit = (count == reload_value);
	assign overflow = step && (count_down ? reload_value_hit : top_hit);
	// Up/down operation uses the trigger as direction, not as event
	assign ext_event = trigger_fall && timer_control[`CTL_EXTERNAL_ENABLE] &&
		(mode == MODE_AUTO_RELOAD || mode == MODE_CAPTURE); // R20 R18

	always_comb begin
		next_count = count;
		next_reload = reload_value;
		if (step) begin
			if (count_down)
				next_count = reload_value_hit ? `COUNT_MAX : count - 16'h0001;
			else if (!top_hit)
				next_count = count + 16'h0001; // R1
			else if (mode == MODE_CAPTURE)
				next_count = `COUNT_MIN; // R13
			else
				next_count = reload_value; // R13
		end
		if (ext_event) begin
			if (mode == MODE_CAPTURE)
				next_reload = count;
			else
				next_count = reload_value;
		end
	end

	// Hardware update first; a software byte write in the same cycle is dropped
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			count <= `RST_COUNT;
		else if (step || ext_event)
			count <= next_count; // R25
		else if (wr_count_low)
			count[7:0] <= wr_byte; // R14
		else if (wr_count_high)
			count[15:8] <= wr_byte;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			reload_value <= `RST_RELOAD;
		else if (ext_event && mode == MODE_CAPTURE)
			reload_value <= next_reload;
		else if (wr_reload_low)
			reload_value[7:0] <= wr_byte; // R14
		else if (wr_reload_high)
			reload_value[15:8] <= wr_byte;
	end

	// Control register: flags are set by hardware over any write
	always_comb begin
		next_control = timer_control;
		if (wr_control)
			next_control = wr_byte;
		if (overflow && !serial_clock)
			next_control[`CTL_OVERFLOW_FLAG] = 1'b1; // R15 R16 R25
		if (ext_event)
			next_control[`CTL_EXTERNAL_FLAG] = 1'b1; // R18 R25
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			timer_control <= `RST_TIMER_CONTROL;
		else
			timer_control <= next_control;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			timer_mode_control <= `RST_TIMER_MODE_CONTROL;
		else if (wr_mode)
			timer_mode_control <= wr_byte & `MOD_WRITE_MASK;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			clock_control <= `RST_CLOCK_CONTROL; // R4
		else if (wr_clock)
			clock_control <= wr_byte & `CLK_WRITE_MASK;
	end

	// Count pin output: driven whenever toggle enable is set in timer use; toggles only as frequency generator
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			count_pin_out <= 1'b0;
		else if (mode == MODE_FREQ && !timer_control[`CTL_COUNTER_SELECT] &&
			overflow)
			count_pin_out <= ~count_pin_out; // R23
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			count_pin_oe <= 1'b0;
		else
			count_pin_oe <= timer_mode_control[`MOD_OUTPUT_TOGGLE] &&
				!timer_control[`CTL_COUNTER_SELECT]; // R23
	end

	// Serial clock pulses, one clock wide
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			receive_clock_pulse <= 1'b0;
			transmit_clock_pulse <= 1'b0;
		end else begin
			receive_clock_pulse <= timer_control[`CTL_RECEIVE_CLOCK] ?
				overflow : other_timer_overflow; // R22
			transmit_clock_pulse <= timer_control[`CTL_TRANSMIT_CLOCK] ?
				overflow : other_timer_overflow;
		end
	end

	// Interrupt request level
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			timer_irq <= 1'b0;
		else
			timer_irq <= clock_control[`CLK_INT_ENABLE] &&
				(timer_control[`CTL_OVERFLOW_FLAG] || // R17
				(timer_control[`CTL_EXTERNAL_FLAG] &&
				!timer_mode_control[`MOD_DOWN_COUNT])); // R19
	end

endmodule : timer2_reload_capture_counter
